/* File: smc_bus_model.sv */
// Far-side stand-in: bus controller area widths and write buffer
`timescale 1ns/10ps
module smc_bus_model (
  input logic ref_clk, // Clock
  input logic wide, // All areas 16-bit
  input logic buf_on, // Buffer wanted
  output logic [7:0] area_is_16, // Area widths
  output logic wbuf_en // Buffer enable
);
  // Settings move on an edge, as a register write would
  always_ff @(posedge ref_clk) begin
    area_is_16 <= {8{wide}};
    wbuf_en <= buf_on;
  end
endmodule

/* File: smc_pkg.sv */
// Types for the system mode control block
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_BUS_OFF = 3'b001,
    SMC_BUS_8 = 3'b010,
    SMC_BUS_16 = 3'b100
  } smc_bus_mode_t;
endpackage

/* File: smc_regs.svh */
// Register offsets, field positions and reset values for the system mode control block
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

`define SMC_ADDR_W 4
`define SMC_SYSCTL_OFS 4'h0
`define SMC_MODE_STAT_OFS 4'h4
`define SMC_BUS_STAT_OFS 4'h8

`define SMC_EXT_EN_BIT 9
`define SMC_RAM_EN_BIT 8
`define SMC_DTC_MODE_BIT 1

// Fixed bits: 15,14,12,0 read 1; 13 and 11 are stored
`define SMC_FIXED_ONE_MASK 16'hd001
`define SMC_STORED_MASK 16'h2b02
`define SMC_MACS_BIT 13
`define SMC_FETCH_BIT 11
`define SMC_RESET_STORED 16'h0102

`define SMC_MODE_EXT16 3'h4
`define SMC_MODE_EXT8 3'h5

// Pin role masks while the external bus is on
`define SMC_PA_CTRL 8'hd0
`define SMC_PB_CTRL 8'h01
`define SMC_PDE_ADDR 8'hff
`define SMC_PF_ADDR 8'h1f

`endif

/* File: smc_system_control.sv */
// System control register and external extended mode pin assignment
// What this block does
// - Extended mode holds external bus enable at one
// - Single-chip: enable resets zero, software writable
// - Enable bit gates the external bus
// - Write buffer allows external with internal cycles
// - RAM enable returns to one at reset
// - RAM enable bit gates on-chip RAM access
// - Bit ten reads zero, write zero
// - Bits seven to two read zero
// - Bit zero reads one, write one
// - Transfer mode bit resets one; selects addressing
// - Modes four and five are extended modes
// - Modes four, five: advanced, 16M, ROM off
// - Mode four starts sixteen-bit, ports D-F address
// - Mode four all 8-bit areas: port H only
// - Mode five starts eight-bit, port H data
// - Mode five all 16-bit areas: H and I
// - Port A/B control and I/O after reset
// - Port F split; port I default by mode
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "smc_regs.svh"

module smc_system_control #(
  parameter int AREAS = 8
) (
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic rstn, // Async reset, active low
  input wire logic [2:0] op_mode, // Latched operating mode, steady out of reset
  input wire logic [`SMC_ADDR_W-1:0] addr, // Register byte address
  input wire logic [15:0] wdata, // Write data
  input wire logic wr_stb, // Write strobe
  input wire logic rd_stb, // Read strobe
  input wire logic [AREAS-1:0] area_is_16, // Per-area 16-bit access setting
  input wire logic wbuf_en, // Write data buffer function enabled
  output logic [15:0] rdata, // Read data, cycle after strobe
  output logic external_bus_enable, // External bus enabled
  output logic onchip_ram_enable, // On-chip RAM access enabled
  output logic transfer_ctrl_addr_mode, // 0 full address, 1 short address
  output logic mac_saturate, // MAC saturation control
  output logic fetch_16bit, // Instruction fetch 16-bit width
  output logic ext_mode, // External extended mode active
  output logic advanced_16m, // Advanced mode, 16 Mbyte space
  output logic onchip_rom_enable, // On-chip ROM enabled
  output logic parallel_ext_ok, // External cycle may overlap internal
  output logic [2:0] bus_mode, // Current bus width mode, one-hot
  output logic [7:0] pa_ctrl, // Port A bits acting as bus control
  output logic [7:0] pb_ctrl, // Port B bits acting as bus control
  output logic [7:0] pd_addr, // Port D bits driving address
  output logic [7:0] pe_addr, // Port E bits driving address
  output logic [7:0] pf_addr, // Port F bits driving address
  output logic ph_data, // Port H carries data
  output logic pi_data // Port I carries data
);

  initial begin
    if (AREAS < 1 || AREAS > 16) begin
      $error("AREAS out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  function automatic logic is_ext_mode(input logic [2:0] m);
    is_ext_mode = (m == `SMC_MODE_EXT16) || (m == `SMC_MODE_EXT8);
  endfunction

  wire logic ext_w = is_ext_mode(op_mode);
  wire logic all8_w = ~|area_is_16;
  wire logic all16_w = &area_is_16;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [15:0] stored_q;
  logic [15:0] stored_d;
  logic exp_q;
  logic exp_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  smc_pkg::smc_bus_mode_t bmode_q;
  smc_pkg::smc_bus_mode_t bmode_d;
  logic init_q;

  wire logic wr_sys = wr_stb && (addr == `SMC_SYSCTL_OFS);
  // Reserved positions masked off, so writes there are dropped
  assign stored_d = wr_sys ? (wdata & `SMC_STORED_MASK) : stored_q;

  // Extended mode forces one; single-chip keeps the written value
  assign exp_d = ext_w ? 1'b1 : (wr_sys ? wdata[`SMC_EXT_EN_BIT] : exp_q);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stored_q <= `SMC_RESET_STORED;
      exp_q <= 1'b0;
    end else begin
      stored_q <= stored_d;
      exp_q <= exp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus width mode: initial width by mode, then one switch to the other width once all areas take it, then held

  always_comb begin
    bmode_d = bmode_q;
    if (!ext_w) begin
      bmode_d = smc_pkg::SMC_BUS_OFF;
    end else if (!init_q) begin
      bmode_d = (op_mode == `SMC_MODE_EXT16) ? smc_pkg::SMC_BUS_16 : smc_pkg::SMC_BUS_8;
    end else if (op_mode == `SMC_MODE_EXT16 && all8_w) begin
      bmode_d = smc_pkg::SMC_BUS_8;
    end else if (op_mode == `SMC_MODE_EXT8 && all16_w) begin
      bmode_d = smc_pkg::SMC_BUS_16;
    end
  end

  // Mode pins are caught after release, never under the reset itself
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bmode_q <= smc_pkg::SMC_BUS_OFF;
      init_q <= 1'b0;
    end else begin
      bmode_q <= bmode_d;
      init_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire logic [15:0] sys_view = stored_q | `SMC_FIXED_ONE_MASK | ({15'h0000, exp_q} << `SMC_EXT_EN_BIT);
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_stb) begin
      unique case (addr)
        `SMC_SYSCTL_OFS: rdata_d = sys_view;
        `SMC_MODE_STAT_OFS: rdata_d = {13'h0000, op_mode};
        `SMC_BUS_STAT_OFS: rdata_d = {13'h0000, bmode_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata = rdata_q;
  assign external_bus_enable = exp_q;
  assign onchip_ram_enable = stored_q[`SMC_RAM_EN_BIT];
  assign transfer_ctrl_addr_mode = stored_q[`SMC_DTC_MODE_BIT];
  assign mac_saturate = stored_q[`SMC_MACS_BIT];
  assign fetch_16bit = stored_q[`SMC_FETCH_BIT];
  assign ext_mode = ext_w;
  assign advanced_16m = ext_w;
  assign onchip_rom_enable = ~ext_w;
  assign parallel_ext_ok = exp_q & wbuf_en;
  assign bus_mode = bmode_q;

  wire logic bus_on = ext_w & exp_q;
  assign pa_ctrl = bus_on ? `SMC_PA_CTRL : 8'h00;
  assign pb_ctrl = bus_on ? `SMC_PB_CTRL : 8'h00;
  assign pd_addr = bus_on ? `SMC_PDE_ADDR : 8'h00;
  assign pe_addr = bus_on ? `SMC_PDE_ADDR : 8'h00;
  assign pf_addr = bus_on ? `SMC_PF_ADDR : 8'h00;
  assign ph_data = bus_on && bmode_q != smc_pkg::SMC_BUS_OFF;
  assign pi_data = bus_on && bmode_q == smc_pkg::SMC_BUS_16;

endmodule

/* File: smc_system_control_properties.sv */
// Port checker for the system mode control block
`timescale 1ns/10ps
module smc_checker (
  input logic ref_clk, rstn, rd_stb, // Clock, reset, read
  input logic [3:0] addr, // Address
  input logic [15:0] rdata, // Read data
  input logic external_bus_enable, ext_mode, advanced_16m, // Mode
  input logic onchip_rom_enable, parallel_ext_ok, wbuf_en, ph_data, pi_data, // Status
  input logic [2:0] bus_mode, // Width
  input logic onchip_ram_enable, // On-chip RAM access enabled
  input logic [7:0] pa_ctrl, pb_ctrl, pd_addr, pe_addr, pf_addr // Pin roles
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_ext_held: assert property (ext_mode |=> external_bus_enable) else $error("ext held");
  a_ram_reset: assert property ($rose(rstn) |-> onchip_ram_enable) else $error("ram reset");
  a_rd_fixed: assert property (rd_stb && addr == 4'h0 |=> (rdata & 16'hd4fd) == 16'hd001) else $error("fixed");
  a_rd_idle: assert property (!rd_stb |=> rdata == 16'h0000) else $error("rdata idle");
  a_bus_gate: assert property (!external_bus_enable |-> !ph_data && pd_addr == 8'h00 && pe_addr == 8'h00)
    else $error("gate");
  a_rom_off: assert property (ext_mode |-> advanced_16m && !onchip_rom_enable) else $error("rom");
  a_par_ok: assert property (parallel_ext_ok == (external_bus_enable && wbuf_en)) else $error("par");
  a_pin_roles: assert property (external_bus_enable && ext_mode |-> pa_ctrl == 8'hd0 && pb_ctrl == 8'h01
    && pf_addr == 8'h1f && pd_addr == 8'hff && pe_addr == 8'hff) else $error("pins");
  a_wide_data: assert property (pi_data |-> ph_data && bus_mode == 3'b100) else $error("wide");
  cover property (rd_stb && addr == 4'h0);
  cover property (ext_mode && bus_mode == 3'b010);
  cover property (parallel_ext_ok);
endmodule
bind smc_system_control smc_checker chk (.ref_clk, .rstn, .rd_stb, .addr, .rdata, .external_bus_enable, .ext_mode,
  .advanced_16m, .onchip_rom_enable, .parallel_ext_ok, .wbuf_en, .ph_data, .pi_data, .bus_mode, .onchip_ram_enable,
  .pa_ctrl, .pb_ctrl, .pd_addr, .pe_addr, .pf_addr);

/* File: smc_system_control_test.sv */
// Self-checking bench for the system mode control block
`timescale 1ns/10ps
module smc_system_control_test;
  logic ref_clk = 0, rstn = 0, wr_stb = 0, rd_stb = 0, wide = 1, buf_on = 0;
  logic [2:0] op_mode = 0, bus_mode;
  logic [3:0] addr = 0;
  logic [15:0] wdata = 0, rdata, v;
  logic [7:0] area_is_16;
  logic wbuf_en, external_bus_enable, parallel_ext_ok, ph_data, pi_data, ram_en, dtc_mode;
  int miscompares = 0, check_count = 0;
  // Rows: written word, then the word read back
  // Reserved bits are written with their fixed values, as software must
  logic [31:0] rows [5] = '{32'hfb03_fb03, 32'hd001_d001, 32'hd201_d201, 32'hd101_d101, 32'hd003_d003};
  initial forever #25 ref_clk = ~ref_clk;
  smc_bus_model far (.ref_clk, .wide, .buf_on, .area_is_16, .wbuf_en);
  smc_system_control uut (.ref_clk, .rstn, .op_mode, .addr, .wdata, .wr_stb, .rd_stb, .area_is_16, .wbuf_en,
    .rdata, .external_bus_enable, .onchip_ram_enable(ram_en), .transfer_ctrl_addr_mode(dtc_mode), .mac_saturate(),
    .fetch_16bit(), .ext_mode(), .advanced_16m(), .onchip_rom_enable(), .parallel_ext_ok, .bus_mode,
    .pa_ctrl(), .pb_ctrl(), .pd_addr(), .pe_addr(), .pf_addr(), .ph_data, .pi_data);
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1;
    @(posedge ref_clk);
    wr_stb <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1;
    @(posedge ref_clk);
    rd_stb <= 0;
    #1 v = rdata;
  endtask
  task boot(input logic [2:0] m, input logic w);
    @(posedge ref_clk);
    op_mode <= m;
    wide <= w;
    rstn <= 0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1;
    repeat (3) @(posedge ref_clk);
  endtask
  task settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    boot(3'h0, 1);
    rd(4'h0);
    chk("reset", 16'hd103, v);
    foreach (rows[i]) begin
      wr(4'h0, rows[i][31:16]);
      rd(4'h0);
      chk("sysctl", rows[i][15:0], v);
      chk("exp", 16'(rows[i][25]), 16'(external_bus_enable));
      chk("ram", 16'(rows[i][24]), 16'(ram_en));
      chk("dtc", 16'(rows[i][17]), 16'(dtc_mode));
    end
    boot(3'h4, 1);
    rd(4'h0);
    chk("ext reset", 16'hd303, v);
    wr(4'h0, 16'hd001);
    rd(4'h0);
    chk("ext write", 16'hd201, v);
    chk("mode4", 16'({bus_mode, ph_data, pi_data}), 16'h0013);
    @(posedge ref_clk) wide <= 0;
    buf_on <= 1;
    settle;
    chk("to 8", 16'({bus_mode, ph_data, pi_data, parallel_ext_ok}), 16'h0015);
    boot(3'h5, 0);
    #1 chk("mode5", 16'({bus_mode, ph_data, pi_data}), 16'h000a);
    @(posedge ref_clk) wide <= 1;
    settle;
    chk("to 16", 16'({bus_mode, ph_data, pi_data}), 16'h0013);
    rd(4'h4);
    chk("mode", 16'h0005, v);
    rd(4'hc);
    chk("unmapped", 16'h0000, v);
    test_done;
  end
  initial begin
    #100000;
    miscompares++;
    test_done;
  end
endmodule
